// File: hw/csb_defines.svh
// Purpose: constants of the clock safeguard block
// Assumes: byte offsets on the register bus
// Notes:   timing counts in pclk cycles; reset delay in internal ticks, start-up in main ticks
`ifndef CSB_DEFINES_SVH
`define CSB_DEFINES_SVH

`define CSB_CTRL_OFFSET        12'h00D1
`define CSB_CTRL_WORD_ADDR     12'h0344
`define CSB_STAT_ADDR          12'h0400
`define CSB_OPT_ADDR           12'h0404
`define CSB_CTRL_RESET         8'h40
`define CSB_OPT_RESET          8'h01
`define CSB_MAIN_OSC_DISABLE_BIT         2
`define CSB_OPT_SAFEGUARD_BIT  0
`define CSB_OPT_OSCTYPE_BIT    6
`define CSB_DIV_TIMER          4'hC
`define CSB_DIV_CORE           4'hD
`define CSB_RESET_DELAY        12'h0800
`define CSB_BACKUP_DIV         8'h20
`define CSB_MISS_LIMIT         8'h10
`define CSB_STARTUP_CYCLES     8'h40
`define CSB_MIN_EDGE_GAP       8'h02

`endif

// File: hw/csb_pkg.sv
// Purpose: types of the clock safeguard block
// Assumes: nothing
// Notes:   constants live in csb_defines.svh
package csb_pkg;
    typedef enum logic [1:0] {
        CSB_SRC_MAIN,
        CSB_SRC_TO_BACKUP,
        CSB_SRC_BACKUP,
        CSB_SRC_TO_MAIN
    } csb_src_type;
endpackage

// File: hw/csb_clock_safeguard.sv
// Purpose: clock safeguard, backup oscillator and clock dividers
// Assumes: main oscillator edges arrive as a sampled level osc_input_pin
// Notes:   the internal clock is an enable pulse, not a clock net
//          the safeguard maximum rate is a minimum gap between accepted
//          rising edges; a faster input simply loses edges
//          a main oscillator counts as missing after a fixed run of pclk
//          cycles with no accepted edge
//          the backup oscillator is a pclk divider, so its period is exact;
//          real silicon would drift with supply and temperature
//          the option byte is a register here, writable only while the
//          reset delay runs, then frozen like programmed fuses
//          converter control bits are passed through untouched
//          returning to main waits for a backup tick at an instruction end,
//          so a core that never ends an instruction stays on backup
//          switching is done on backup ticks, except back to main on a safeguard drop
//
// Function
// - timer clock is internal/12, core /13, auto-reload timer /1 or /3.
// - writing one to control bit 2 stops the main oscillator.
// - the oscillator-off bit acts only with safeguard option enabled.
// - software stop with safeguard on starts backup and runs from it.
// - backup starts one backup period after first missing main edge.
// - no backup oscillator or switch-over when safeguard disabled.
// - reset delay counter runs on backup until main runs, then main.
// - backup oscillator switches off once the main oscillator has started.
// - return to main waits start-up period plus current instruction.
// - on backup the core keeps running normally at the reduced rate.
// - safeguard filters spikes and caps the internal clock rate.
// - over-fast input loses cycles so the internal clock stays in range.
// - control register at 0D1h, read/write, reset value 40h.
// - control bits 7:3 and 1:0 are converter control, otherwise unused.
// - option bit 0 zero disables, one enables the safeguard.
// - option bit 6 zero crystal/resonator/clock, one RC network.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "csb_defines.svh"

module csb_clock_safeguard
    import csb_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        osc_input_pin,
    input  wire logic        instr_boundary,
    input  wire logic [1:0]  art_div_sel,
    output logic             main_osc_enable,
    output logic             rc_mode,
    output logic             low_freq_backup_osc,
    output logic             int_clk_en,
    output logic             timer_clk_en,
    output logic             core_clk_en,
    output logic             art_clk_en,
    output logic             reset_delay_done,
    output logic [7:0]       converter_control_bits
);
    import csb_pkg::*;

    // ********************************************************
    // functions
    // ********************************************************
    // wrap counter of modulus lim
    function automatic logic [3:0] div_next(input logic [3:0] cnt,
                                            input logic [3:0] lim);
        div_next = (cnt == lim - 4'h1) ? 4'h0 : cnt + 4'h1;
    endfunction

    // saturating increment
    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v == 8'hFF) ? v : v + 8'h01;
    endfunction

    // ********************************************************
    // register bus
    // ********************************************************
    logic [7:0]  ctrl_r;
    logic [7:0]  opt_r;
    logic        strap_done_r;
    csb_src_type src_r;
    logic        backup_on_r;

    // byte lane 0 carries every register
    wire logic access    = psel & penable;
    wire logic hit_ctrl  = (paddr == `CSB_CTRL_WORD_ADDR);
    wire logic hit_stat  = (paddr == `CSB_STAT_ADDR);
    wire logic hit_opt   = (paddr == `CSB_OPT_ADDR);
    wire logic hit_any   = hit_ctrl | hit_stat | hit_opt;
    wire logic wr_ctrl   = access & pwrite & hit_ctrl & pstrb[0];
    wire logic wr_opt    = access & pwrite & hit_opt & pstrb[0];

    // zero wait states: every access completes in its first cycle
    assign pready  = 1'b1;
    assign pslverr = access & ~hit_any;

    // status word: backup running, delay done, source code
    wire logic [31:0] rd_mux =
        hit_ctrl ? {24'h0000_00, ctrl_r} :
        hit_opt  ? {24'h0000_00, opt_r} :
        hit_stat ? {28'h0000_000, backup_on_r, reset_delay_done,
                    src_r} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        // captured in the setup cycle; holds until the next read
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= rd_mux;
        end
    end

    // full byte stored; all eight bits, bit 2 included, go to the converter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `CSB_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= pwdata[7:0];
        end
    end
    assign converter_control_bits = ctrl_r;

    // option byte: writable only until the reset delay ends, then frozen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_r        <= `CSB_OPT_RESET;
            strap_done_r <= 1'b0;
        end else begin
            if (wr_opt && !strap_done_r) begin
                opt_r <= pwdata[7:0];
            end
            strap_done_r <= reset_delay_done;
        end
    end

    wire logic safeguard_on = opt_r[`CSB_OPT_SAFEGUARD_BIT];
    assign rc_mode = opt_r[`CSB_OPT_OSCTYPE_BIT];
    wire logic sw_stop = safeguard_on & ctrl_r[`CSB_MAIN_OSC_DISABLE_BIT];
    assign main_osc_enable = ~sw_stop;

    // ********************************************************
    // main oscillator edge detect and spike filter
    // ********************************************************
    logic       osc_d_r;
    logic [7:0] gap_r;
    logic [7:0] miss_r;

    wire logic osc_rise = osc_input_pin & ~osc_d_r;
    // a rise closer than the minimum gap is a spike or overspeed
    wire logic too_fast = safeguard_on && (gap_r < `CSB_MIN_EDGE_GAP);
    wire logic main_tick = osc_rise & main_osc_enable & ~too_fast;

    // counters saturate so a long stop never wraps into a false edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_d_r <= 1'b0;
            gap_r   <= 8'h00;
            miss_r  <= 8'h00;
        end else begin
            osc_d_r <= osc_input_pin;
            gap_r   <= main_tick ? 8'h00 : sat_inc(gap_r);
            miss_r  <= main_tick ? 8'h00 : sat_inc(miss_r);
        end
    end

    // a software stop counts as missing at once, no timeout needed
    wire logic main_missing = ~main_osc_enable |
                              (miss_r >= `CSB_MISS_LIMIT);

    // ********************************************************
    // backup oscillator
    // ********************************************************
    logic [7:0] bk_cnt_r;
    wire  logic bk_tick = backup_on_r && (bk_cnt_r == `CSB_BACKUP_DIV - 8'h01);

    // idles at zero, so each start gives one full period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bk_cnt_r <= 8'h00;
        end else if (!backup_on_r || bk_tick) begin
            bk_cnt_r <= 8'h00;
        end else begin
            bk_cnt_r <= bk_cnt_r + 8'h01;
        end
    end
    assign low_freq_backup_osc = backup_on_r;

    // ********************************************************
    // source selection
    // ********************************************************
    logic [7:0] wait_r;
    logic [7:0] start_r;

    // switches on a backup tick, except back to main on a safeguard drop: no short phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_r       <= CSB_SRC_MAIN;
            backup_on_r <= 1'b0;
            wait_r      <= 8'h00;
            start_r     <= 8'h00;
        end else begin
            case (src_r)
                CSB_SRC_MAIN: begin
                    start_r <= 8'h00;
                    if (safeguard_on && main_missing) begin
                        src_r       <= CSB_SRC_TO_BACKUP;
                        backup_on_r <= 1'b1;
                        wait_r      <= 8'h00;
                    end
                end
                CSB_SRC_TO_BACKUP: begin
                    // one full backup period before it drives the clock
                    if (bk_tick) begin
                        src_r <= CSB_SRC_BACKUP;
                    end
                end
                CSB_SRC_BACKUP: begin
                    // safeguard dropped: no backup allowed, back to main
                    if (!safeguard_on) begin
                        src_r       <= CSB_SRC_MAIN;
                        backup_on_r <= 1'b0;
                    end else if (main_tick) begin
                        // start-up ticks; a gap of CSB_MISS_LIMIT pclk cycles restarts the count
                        start_r <= sat_inc(start_r);
                        if (start_r >= `CSB_STARTUP_CYCLES) begin
                            src_r <= CSB_SRC_TO_MAIN;
                        end
                    end else if (main_missing) begin
                        start_r <= 8'h00;
                    end
                end
                CSB_SRC_TO_MAIN: begin
                    // finish the running instruction at the backup rate
                    if (bk_tick && instr_boundary) begin
                        src_r       <= CSB_SRC_MAIN;
                        backup_on_r <= 1'b0;
                    end else if (main_missing) begin
                        // main failed again before the switch
                        src_r   <= CSB_SRC_BACKUP;
                        start_r <= 8'h00;
                    end
                end
                default: begin
                    // unreachable code, recover to main
                    src_r <= CSB_SRC_MAIN;
                end
            endcase
        end
    end

    // ********************************************************
    // internal tick
    // ********************************************************
    wire logic on_backup = (src_r == CSB_SRC_BACKUP) |
                           (src_r == CSB_SRC_TO_MAIN);
    // a main edge right after the last backup tick would give a short
    // phase at the switch back, so it is dropped
    wire logic main_gated = main_tick & ~int_clk_en;
    // core runs on whichever source is selected, nothing else changes
    wire logic int_tick = on_backup ? bk_tick : main_gated;

    // ********************************************************
    // dividers
    // ********************************************************
    // advance on internal ticks only and never reset on a switch,
    // so divided clocks keep their ratio across a switch
    logic [3:0] div12_r;
    logic [3:0] div13_r;
    logic [1:0] div3_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div12_r <= 4'h0;
            div13_r <= 4'h0;
            div3_r  <= 2'b00;
        end else if (int_tick) begin
            div12_r <= div_next(div12_r, `CSB_DIV_TIMER);
            div13_r <= div_next(div13_r, `CSB_DIV_CORE);
            div3_r  <= (div3_r == 2'b10) ? 2'b00 : div3_r + 2'b01;
        end
    end

    wire logic t12_hit = int_tick && (div12_r == `CSB_DIV_TIMER - 4'h1);
    wire logic t13_hit = int_tick && (div13_r == `CSB_DIV_CORE - 4'h1);
    // auto-reload timer: select bit 0 picks /3, else /1
    wire logic t3_hit  = int_tick && (div3_r == 2'b10);
    wire logic art_hit = art_div_sel[0] ? t3_hit : int_tick;

    // ********************************************************
    // reset delay counter
    // ********************************************************
    // counts internal ticks, so its length follows the source
    logic [11:0] rst_cnt_r;
    logic        rst_done_r;

    // clocked by the selected source, backup until main has started
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt_r  <= 12'h000;
            rst_done_r <= 1'b0;
        end else if (int_tick && !rst_done_r) begin
            rst_cnt_r <= rst_cnt_r + 12'h001;
            if (rst_cnt_r == `CSB_RESET_DELAY - 12'h001) begin
                rst_done_r <= 1'b1;
            end
        end
    end
    assign reset_delay_done = rst_done_r;

    // ********************************************************
    // outputs
    // ********************************************************
    // registered: one pclk after the tick, glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_clk_en   <= 1'b0;
            timer_clk_en <= 1'b0;
            core_clk_en  <= 1'b0;
            art_clk_en   <= 1'b0;
        end else begin
            int_clk_en   <= int_tick;
            timer_clk_en <= t12_hit;
            core_clk_en  <= t13_hit & rst_done_r;
            art_clk_en   <= art_hit;
        end
    end

endmodule
`default_nettype wire

// File: bench/csb_osc_model.sv
// Purpose: behavioural main oscillator on the board side
// Assumes: the device samples the pin on pclk
// Notes:   a stopped oscillator holds its level
`timescale 1ns/100ps
`default_nettype none
module csb_osc_model #(
    parameter int HALF = 2
) (
    input  wire logic pclk,
    input  wire logic run,
    output logic      osc_input_pin
);
    logic pin_r = 1'b0;
    int   cnt_r = 0;
    assign osc_input_pin = pin_r;
    always @(posedge pclk) begin
        if (run && cnt_r >= HALF - 1) begin
            cnt_r <= 0;
            pin_r <= !pin_r;
        end else if (run) begin
            cnt_r <= cnt_r + 1;
        end
    end
endmodule
`default_nettype wire

// File: bench/csb_clock_safeguard_properties.sv
// Purpose: port checks of the clock safeguard
// Assumes: zero-wait APB, one-cycle clock pulses
// Notes:   timer and core divider checks arm after a first pulse
`timescale 1ns/100ps
`default_nettype none
`include "csb_defines.svh"
module csb_clock_safeguard_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  art_div_sel,
    input wire logic        main_osc_enable,
    input wire logic        low_freq_backup_osc,
    input wire logic        int_clk_en,
    input wire logic        timer_clk_en,
    input wire logic        core_clk_en,
    input wire logic        art_clk_en,
    input wire logic        reset_delay_done,
    input wire logic [7:0]  converter_control_bits
);
    logic [4:0] tcnt_r, ccnt_r;
    logic       tarm_r, carm_r;
    wire  logic mapped = paddr == `CSB_CTRL_WORD_ADDR
        || paddr == `CSB_STAT_ADDR || paddr == `CSB_OPT_ADDR;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ********
    // internal ticks since the last divided pulse
    // ********
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcnt_r <= 5'h00;
            ccnt_r <= 5'h00;
            tarm_r <= 1'b0;
            carm_r <= 1'b0;
        end else begin
            tcnt_r <= timer_clk_en ? 5'h00 : tcnt_r + 5'(int_clk_en);
            ccnt_r <= core_clk_en ? 5'h00 : ccnt_r + 5'(int_clk_en);
            tarm_r <= tarm_r | timer_clk_en;
            carm_r <= carm_r | core_clk_en;
        end
    end
    sequence ctrl_wr_s;
        psel && penable && pwrite && pstrb[0] && paddr == `CSB_CTRL_WORD_ADDR;
    endsequence
    ctrl_reset_a: assert property (
        $rose(presetn) |-> converter_control_bits == `CSB_CTRL_RESET)
        else $error("control not at reset value");
    ctrl_write_a: assert property (
        ctrl_wr_s |=> converter_control_bits == $past(pwdata[7:0]))
        else $error("control write lost");
    bus_resp_a: assert property (
        psel && penable |-> pready && pslverr == !mapped)
        else $error("bad bus response");
    osc_enable_a: assert property (
        !converter_control_bits[2] |-> main_osc_enable)
        else $error("main oscillator off without request");
    backup_start_a: assert property (
        $fell(main_osc_enable) |-> ##[1:400] low_freq_backup_osc)
        else $error("backup did not start");
    timer_div_a: assert property (
        timer_clk_en && tarm_r |-> tcnt_r + 5'(int_clk_en) == 5'h0C)
        else $error("timer divide wrong");
    core_div_a: assert property (
        core_clk_en && carm_r |-> ccnt_r + 5'(int_clk_en) == 5'h0D)
        else $error("core divide wrong");
    art_pass_a: assert property (
        !art_div_sel[0] && !$past(art_div_sel[0]) |-> art_clk_en == int_clk_en)
        else $error("timer divide by one wrong");
    tick_gap_a: assert property (
        int_clk_en |=> !int_clk_en)
        else $error("internal ticks too close");
    core_gate_a: assert property (
        core_clk_en |-> reset_delay_done)
        else $error("core clock before reset delay");
endmodule
bind csb_clock_safeguard csb_clock_safeguard_properties
    u_csb_clock_safeguard_properties (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .pslverr, .art_div_sel, .main_osc_enable, .low_freq_backup_osc,
    .int_clk_en, .timer_clk_en, .core_clk_en, .art_clk_en,
    .reset_delay_done, .converter_control_bits
);
`default_nettype wire

// File: bench/tb.sv
// Purpose: self-checking bench of the clock safeguard
// Assumes: oscillator rise every 4 pclk, zero-wait APB
// Notes:   safeguard-off case runs first, before the option locks
`timescale 1ns/100ps
`default_nettype none
`include "csb_defines.svh"
module tb;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, instr_boundary = 1'b0, osc_run = 1'b1;
    logic        ib_en = 1'b1, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [3:0]  pstrb = 4'hF;
    logic [1:0]  art_div_sel = 2'h0;
    logic [7:0]  converter_control_bits;
    logic        pready, pslverr, osc_input_pin, main_osc_enable, rc_mode;
    logic        low_freq_backup_osc, int_clk_en, timer_clk_en, core_clk_en;
    logic        art_clk_en, reset_delay_done;
    int          mismatches = 0, compares = 0, cyc = 0;
    csb_clock_safeguard u_csb_clock_safeguard (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .osc_input_pin, .instr_boundary,
        .art_div_sel, .main_osc_enable, .rc_mode, .low_freq_backup_osc,
        .int_clk_en, .timer_clk_en, .core_clk_en, .art_clk_en,
        .reset_delay_done, .converter_control_bits
    );
    // the crystal stops while the device holds it off
    csb_osc_model u_csb_osc_model (
        .pclk, .run(osc_run && main_osc_enable), .osc_input_pin
    );
    initial begin
        forever #2 pclk = ~pclk;
    end
    // ********
    // timeout and instruction ends
    // ********
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        // long level, so some backup tick always meets it
        instr_boundary <= ib_en && cyc[5];
        if (cyc == 30000) begin
            mismatches++;
            test_done();
        end
    end
    task test_done;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rst;
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task wait_bk(input logic v, input int lim, input string nm);
        int i;
        i = 0;
        while (low_freq_backup_osc !== v && i < lim) begin
            @(posedge pclk);
            i++;
        end
        chk(nm, {31'h0, v}, low_freq_backup_osc);
    endtask
    function logic pick(input int s);
        return s == 0 ? timer_clk_en : s == 1 ? core_clk_en : art_clk_en;
    endfunction
    task gap(input int s, input logic [31:0] exp, input string nm);
        int n;
        n = 0;
        do @(posedge pclk); while (pick(s) !== 1'b1);
        do begin
            @(posedge pclk);
            n += int_clk_en;
        end while (pick(s) !== 1'b1);
        chk(nm, exp, n);
    endtask
    task t_opt;
        rst();
        apb(1'b1, `CSB_OPT_ADDR, 32'h0000_0040, 4'hF);
        apb(1'b0, `CSB_OPT_ADDR, 32'h0000_0000, 4'hF);
        chk("option", 32'h0000_0040, rd);
        chk("rc_mode", 1'h1, rc_mode);
        apb(1'b1, `CSB_CTRL_WORD_ADDR, 32'h0000_0044, 4'hF);
        @(posedge pclk);
        chk("osc_enable", 1'h1, main_osc_enable);
        osc_run <= 1'b0;
        repeat (300) @(posedge pclk);
        chk("no backup", 1'h0, low_freq_backup_osc);
        $display("test option done");
    endtask
    task t_boot;
        int i;
        rst();
        wait_bk(1'b1, 400, "backup at power on");
        osc_run <= 1'b1;
        wait_bk(1'b0, 2000, "backup off");
        for (i = 0; i < 12000 && reset_delay_done !== 1'b1; i++) @(posedge pclk);
        chk("delay done", 1'h1, reset_delay_done);
        chk("rc_mode", 1'h0, rc_mode);
        apb(1'b0, `CSB_CTRL_WORD_ADDR, 32'h0000_0000, 4'hF);
        chk("control", 32'h0000_0040, rd);
        $display("test boot done");
    endtask
    task t_regs;
        apb(1'b1, `CSB_CTRL_WORD_ADDR, 32'h0000_00FB, 4'hF);
        apb(1'b1, `CSB_CTRL_WORD_ADDR, 32'h0000_0000, 4'hE);
        apb(1'b0, `CSB_CTRL_WORD_ADDR, 32'h0000_0000, 4'hF);
        chk("control", 32'h0000_00FB, rd);
        chk("osc_enable", 1'h1, main_osc_enable);
        apb(1'b1, `CSB_OPT_ADDR, 32'h0000_0000, 4'hF);
        apb(1'b0, `CSB_OPT_ADDR, 32'h0000_0000, 4'hF);
        chk("option", 32'h0000_0001, rd);
        apb(1'b0, 12'h008, 32'h0000_0000, 4'hF);
        chk("unmapped err", 1'h1, er);
        chk("unmapped data", 32'h0000_0000, rd);
        $display("test registers done");
    endtask
    task t_div;
        gap(0, 32'h0000_000C, "timer div");
        gap(1, 32'h0000_000D, "core div");
        art_div_sel <= 2'h1;
        gap(2, 32'h0000_0003, "art div3");
        art_div_sel <= 2'h0;
        gap(2, 32'h0000_0001, "art div1");
        $display("test dividers done");
    endtask
    task t_soft;
        int n;
        n = 0;
        apb(1'b1, `CSB_CTRL_WORD_ADDR, 32'h0000_0044, 4'hF);
        @(posedge pclk);
        chk("osc_enable", 1'h0, main_osc_enable);
        wait_bk(1'b1, 400, "backup on stop");
        repeat (256) begin
            @(posedge pclk);
            n += int_clk_en;
        end
        chk("slow ticks", 1'h1, n >= 7 && n <= 9);
        ib_en <= 1'b0;
        apb(1'b1, `CSB_CTRL_WORD_ADDR, 32'h0000_0040, 4'hF);
        repeat (600) @(posedge pclk);
        chk("backup held", 1'h1, low_freq_backup_osc);
        ib_en <= 1'b1;
        wait_bk(1'b0, 300, "backup back off");
        osc_run <= 1'b0;
        wait_bk(1'b1, 400, "backup on failure");
        osc_run <= 1'b1;
        wait_bk(1'b0, 2000, "backup off again");
        $display("test backup done");
    endtask
    initial begin
        t_opt();
        t_boot();
        t_regs();
        t_div();
        t_soft();
        test_done();
    end
endmodule
`default_nettype wire
